// ---- verilog/etm_timer_ctrl.sv ----
// What this block does
// R1: clock select: sys/4, sys, high/16, high/64, timebase, pin rise, pin fall
// R2: clock select code 101 gives the counter no clock at all
// R3: on rising clears counter then runs; off: no counting, powered down
// R4: counter-on falling holds the counter value until switched on again
// R5: compare mode: counter-on rising returns each pin to its initial level
// R6: period value n matches at n times 128 clocks; zero means 1024
// R7: period value zero never clears; counter overflows at its maximum
// R8: clear select 0 clears on period match, or overflow when period is zero
// R9: clear select 1 clears the counter on channel A compare match
// R10: clear select ignored in single pulse and capture modes
// R11: channel A mode: compare, capture, pwm or single pulse, timer
// R12: channel B has same mode coding; its function drives all three pins
// R13: software switches off before mode change; no pin drive in timer mode
// R14: compare mode match makes pin hold, go low, go high or toggle
// R15: software sets forced level unlike initial level for visible change
// R16: pwm mode function forces inactive, forces active, pwm, or single pulse
// R17: capture mode function selects rising, falling, both edges, or none
// R18: software changes pwm pin functions only while switched off
// R19: level bit is initial level in compare, active level in pwm
// R20: invert bit inverts the channel pin; no effect in timer mode
// R21: read-only direction flag shows 0 counting up, 1 counting down
// R22: alignment selects edge, or centre with match on up, down, either
// R23: counter is ten bits, counting up or down on the selected clock
// R24: pause bit freezes the counter; clearing it resumes from held value
// R25: external clock pin is synchronised; each selected edge counts once
// R26: control fields read back as written, except the channel A direction bit, and reset to zero
`timescale 1ns/1ps
`default_nettype none

module etm_timer_ctrl
(
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic                highSpeedTick,
  input  wire logic                timebaseTick,
  input  wire logic                extCountPin,
  input  wire etm_pkg::etm_wb_req_t wbReq,
  output logic                     wbAck,
  output logic [31:0]              wbDat,
  input  wire logic                chanAPinIn,
  output logic                     chanAPinOut,
  output logic                     chanAPinOe,
  input  wire logic                chanBPin0In,
  output logic [2:0]               chanBPinOut,
  output logic [2:0]               chanBPinOe,
  output logic                     moduleActive
);
  import etm_pkg::*;

  etm_state_t  s_q;
  etm_state_t  s_d;
  etm_clksel_t clkSel;
  etm_mode_t   modeA;
  etm_mode_t   modeB;
  logic [2:0]  period;
  logic [1:0]  align;
  logic        on;
  logic        onRise;
  logic        srcTick;
  logic        run;
  logic        extRise;
  logic        extFall;
  logic        singlePulse;
  logic        centre;
  logic        clrOnA;
  logic        periodHit;
  logic        matchA;
  logic        matchB;
  logic        hitA;
  logic        hitB;
  logic        bottom;
  logic        busHit;
  logic        capA;
  logic        capB;
  logic [9:0]  top;

  // next pin level of one channel from its control byte and events
  function automatic logic nextLevel(input logic [7:0] ctl,
                                     input logic lvl,
                                     input logic rise,
                                     input logic onNow,
                                     input logic hit,
                                     input logic bot,
                                     input logic down);
    logic [1:0] fn;
    logic       act;
    fn  = ctl[CH_FN_LSB +: 2];
    act = ctl[CH_LVL];
    nextLevel = lvl;
    case (etm_mode_t'(ctl[CH_MODE_LSB +: 2]))
      MODE_COMPARE:
      begin
        if (rise)
          nextLevel = act; // R5 R19
        else if (hit)
        begin
          case (fn) // R14
            FN_LOW:    nextLevel = 1'b0;
            FN_HIGH:   nextLevel = 1'b1;
            FN_TOGGLE: nextLevel = ~lvl;
            default:   nextLevel = lvl;
          endcase
        end
      end
      MODE_PWM:
      begin
        case (fn) // R16 R19
          FN_INACTIVE: nextLevel = ~act;
          FN_ACTIVE:   nextLevel = act;
          FN_PWM:
          begin
            if (rise || bot)
              nextLevel = act;
            else if (hit)
              nextLevel = down ? act : ~act;
          end
          default:
          begin
            if (rise)
              nextLevel = act;
            else if (hit || !onNow)
              nextLevel = ~act;
          end
        endcase
      end
      default: nextLevel = lvl;
    endcase
  endfunction : nextLevel

  assign clkSel      = etm_clksel_t'(s_q.ctrl0[CTRL0_CK_LSB +: 3]);
  assign modeA       = etm_mode_t'(s_q.chanA[CH_MODE_LSB +: 2]); // R11
  assign modeB       = etm_mode_t'(s_q.chanB[CH_MODE_LSB +: 2]); // R12
  assign period      = s_q.ctrl0[CTRL0_RP_LSB +: 3];
  assign align       = s_q.chanB[CHB_ALN_LSB +: 2];
  assign on          = s_q.ctrl0[CTRL0_ON];
  assign singlePulse = (modeA == MODE_PWM)
                       && (s_q.chanA[CH_FN_LSB +: 2] == FN_SINGLE);
  assign centre      = (modeA == MODE_PWM) && (align != ALN_EDGE)
                       && !singlePulse;
  assign busHit      = wbReq.cyc && wbReq.stb && !s_q.ack;

  always_comb
  begin
    s_d = s_q;
    // clock source enables, all in the ref_clk domain
    s_d.div4 = s_q.div4 + 2'h1;
    if (highSpeedTick)
      s_d.divH = s_q.divH + 6'h1;
    s_d.extSync = {s_q.extSync[0], extCountPin}; // R25
    s_d.extPrev = s_q.extSync[1];
    extRise = s_q.extSync[1] && !s_q.extPrev; // R25
    extFall = !s_q.extSync[1] && s_q.extPrev;
    case (clkSel) // R1
      CK_SYS4:     srcTick = (s_q.div4 == DIV4_LAST);
      CK_SYS:      srcTick = 1'b1;
      CK_H16:      srcTick = highSpeedTick
                             && (s_q.divH[3:0] == DIV16_LAST);
      CK_H64:      srcTick = highSpeedTick && (s_q.divH == DIV64_LAST);
      CK_TBC:      srcTick = timebaseTick;
      CK_EXT_RISE: srcTick = extRise;
      CK_EXT_FALL: srcTick = extFall;
      default:     srcTick = 1'b0; // R2
    endcase
    onRise = on && !s_q.onPrev;
    s_d.onPrev = on;
    run = on && !s_q.ctrl0[CTRL0_PAUSE] && srcTick && !onRise; // R3 R4 R24
    top = (period == 3'b000) ? CNT_MAX : {period, 7'h00} - 10'h001;
    periodHit = (period != 3'b000) // R6
                && (s_q.cnt == {period - 3'h1, PERIOD_LOW});
    clrOnA = s_q.chanA[CHA_CLR] && !singlePulse
             && (modeA != MODE_CAPTURE); // R10
    matchA = run && (s_q.cnt == s_q.cmpA);
    matchB = run && (s_q.cnt == s_q.cmpB);
    bottom = run && (s_q.cnt == 10'h000);
    // alignment decides which count direction qualifies a match
    hitA = matchA;
    hitB = matchB;
    if (centre)
    begin
      case (align) // R22
        ALN_UP:
        begin
          hitA = matchA && !s_q.dirDown;
          hitB = matchB && !s_q.dirDown;
        end
        ALN_DOWN:
        begin
          hitA = matchA && s_q.dirDown;
          hitB = matchB && s_q.dirDown;
        end
        default:
        begin
          hitA = matchA;
          hitB = matchB;
        end
      endcase
    end
    // counter
    if (onRise)
    begin
      s_d.cnt = 10'h000; // R3
      s_d.dirDown = 1'b0;
    end
    else if (run) // R23
    begin
      if (centre)
      begin
        if (!s_q.dirDown && (s_q.cnt == top))
        begin
          s_d.dirDown = 1'b1; // R21
          s_d.cnt = s_q.cnt - 10'h001;
        end
        else if (s_q.dirDown && (s_q.cnt == 10'h000))
        begin
          s_d.dirDown = 1'b0;
          s_d.cnt = 10'h001;
        end
        else if (s_q.dirDown)
          s_d.cnt = s_q.cnt - 10'h001;
        else
          s_d.cnt = s_q.cnt + 10'h001;
      end
      else if (clrOnA && (s_q.cnt == s_q.cmpA))
        s_d.cnt = 10'h000; // R9
      else if (!clrOnA && periodHit)
        s_d.cnt = 10'h000; // R8
      else
        s_d.cnt = s_q.cnt + 10'h001; // R7
    end
    // output levels
    s_d.lvlA = nextLevel(s_q.chanA, s_q.lvlA, onRise, on, hitA, bottom,
                         s_q.dirDown);
    s_d.lvlB = nextLevel(s_q.chanB, s_q.lvlB, onRise, on, hitB, bottom,
                         s_q.dirDown);
    // capture pins
    s_d.capSyncA = {s_q.capSyncA[0], chanAPinIn};
    s_d.capPrevA = s_q.capSyncA[1];
    s_d.capSyncB = {s_q.capSyncB[0], chanBPin0In};
    s_d.capPrevB = s_q.capSyncB[1];
    case (s_q.chanA[CH_FN_LSB +: 2]) // R17
      CAP_RISE: capA = s_q.capSyncA[1] && !s_q.capPrevA;
      CAP_FALL: capA = !s_q.capSyncA[1] && s_q.capPrevA;
      CAP_BOTH: capA = s_q.capSyncA[1] != s_q.capPrevA;
      default:  capA = 1'b0;
    endcase
    case (s_q.chanB[CH_FN_LSB +: 2]) // R17
      CAP_RISE: capB = s_q.capSyncB[1] && !s_q.capPrevB;
      CAP_FALL: capB = !s_q.capSyncB[1] && s_q.capPrevB;
      CAP_BOTH: capB = s_q.capSyncB[1] != s_q.capPrevB;
      default:  capB = 1'b0;
    endcase
    capA = capA && on && (modeA == MODE_CAPTURE);
    capB = capB && on && (modeB == MODE_CAPTURE);
    // single pulse ends on channel A match
    if (singlePulse && matchA)
      s_d.ctrl0[CTRL0_ON] = 1'b0;
    // register bus, one-cycle answer
    s_d.ack = busHit;
    if (busHit && wbReq.we && wbReq.sel[0]) // R26
    begin
      case (wbReq.adr)
        ADDR_CTRL0: s_d.ctrl0 = wbReq.dat[7:0];
        ADDR_CHANA: s_d.chanA = wbReq.dat[7:0];
        ADDR_CHANB: s_d.chanB = wbReq.dat[7:0];
        ADDR_CMPA:  s_d.cmpA[7:0] = wbReq.dat[7:0];
        ADDR_CMPB:  s_d.cmpB[7:0] = wbReq.dat[7:0];
        default:    s_d.ack = busHit;
      endcase
    end
    if (busHit && wbReq.we && wbReq.sel[1])
    begin
      case (wbReq.adr)
        ADDR_CMPA: s_d.cmpA[9:8] = wbReq.dat[9:8];
        ADDR_CMPB: s_d.cmpB[9:8] = wbReq.dat[9:8];
        default:   s_d.ack = busHit;
      endcase
    end
    if (busHit)
    begin
      case (wbReq.adr)
        ADDR_CTRL0: s_d.rdat = {24'h000000, s_q.ctrl0};
        ADDR_CHANA: s_d.rdat = {24'h000000, s_q.chanA[7:2], s_q.dirDown,
                                s_q.chanA[CHA_CLR]}; // R21
        ADDR_CHANB: s_d.rdat = {24'h000000, s_q.chanB};
        ADDR_CMPA:  s_d.rdat = {22'h000000, s_q.cmpA};
        ADDR_CMPB:  s_d.rdat = {22'h000000, s_q.cmpB};
        ADDR_COUNT: s_d.rdat = {22'h000000, s_q.cnt};
        default:    s_d.rdat = 32'h00000000;
      endcase
    end
    // hardware capture and pin trigger win over a bus write
    if (capA)
      s_d.cmpA = s_q.cnt;
    if (capB)
      s_d.cmpB = s_q.cnt;
    if (singlePulse && extRise)
      s_d.ctrl0[CTRL0_ON] = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_q <= '0; // R26
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wbAck        = s_q.ack;
  assign wbDat        = s_q.rdat;
  assign moduleActive = on; // R3
  // pins driven only in compare and pwm modes
  assign chanAPinOe   = (modeA == MODE_COMPARE) || (modeA == MODE_PWM); // R13
  assign chanAPinOut  = s_q.lvlA ^ s_q.chanA[CH_INV]; // R20
  assign chanBPinOe   = {3{(modeB == MODE_COMPARE) || (modeB == MODE_PWM)}};
  assign chanBPinOut  = {3{s_q.lvlB ^ s_q.chanB[CH_INV]}}; // R12 R20

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_bus_ack_next: assert property (busHit |=> wbAck ##1 !wbAck)
    else $error("bus answer not one cycle after request");
  a_on_rise_clear: assert property ($rose(on) |=> s_q.cnt == 10'h000) // R3
    else $error("counter not cleared when switched on");
  a_off_holds: assert property (!on |=> s_q.cnt == $past(s_q.cnt)) // R4
    else $error("counter moved while switched off");
  a_undef_clock: assert property (clkSel == CK_UNDEF && !onRise // R2
    |=> $stable(s_q.cnt))
    else $error("counter moved with undefined clock");
  a_pause_freeze: assert property (s_q.ctrl0[CTRL0_PAUSE] && on && !onRise
    |=> $stable(s_q.cnt)) // R24
    else $error("counter moved while paused");
  a_period_clear: assert property (run && !centre && !clrOnA && periodHit
    |=> s_q.cnt == 10'h000) // R8
    else $error("period match did not clear counter");
  a_chan_a_clear: assert property (run && !centre && clrOnA && matchA
    |=> s_q.cnt == 10'h000) // R9
    else $error("channel A match did not clear counter");
  a_initial_level: assert property (onRise && modeA == MODE_COMPARE
    |=> s_q.lvlA == $past(s_q.chanA[CH_LVL])) // R5
    else $error("pin not returned to initial level");
  a_toggle_match: assert property (hitA && !onRise && modeA == MODE_COMPARE
    && s_q.chanA[CH_FN_LSB +: 2] == FN_TOGGLE
    |=> s_q.lvlA != $past(s_q.lvlA)) // R14
    else $error("toggle did not change pin");
  a_timer_no_pin: assert property (modeB == MODE_TIMER
    |-> chanBPinOe == 3'b000) // R13
    else $error("pin driven in timer mode");
  a_ext_edge_only: assert property (clkSel == CK_EXT_RISE && !extRise
    && !onRise |=> $stable(s_q.cnt)) // R25
    else $error("counter moved without pin edge");

  c_period_wrap: cover property (run && periodHit ##1 s_q.cnt == 10'h000);
  c_centre_turn: cover property (centre && $rose(s_q.dirDown));
  c_capture_a: cover property (capA);
  c_single_end: cover property (singlePulse && matchA ##1 !on);

endmodule : etm_timer_ctrl

`default_nettype wire

// ---- verilog/etm_pkg.sv ----
package etm_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CHANA = 8'h04;
  localparam logic [7:0] ADDR_CHANB = 8'h08;
  localparam logic [7:0] ADDR_CMPA  = 8'h0c;
  localparam logic [7:0] ADDR_CMPB  = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;

  // timer_clock_on_period_ctrl fields
  localparam int unsigned CTRL0_PAUSE  = 7;
  localparam int unsigned CTRL0_CK_LSB = 4;
  localparam int unsigned CTRL0_ON     = 3;
  localparam int unsigned CTRL0_RP_LSB = 0;
  // channel_a_ctrl / channel_b_ctrl fields
  localparam int unsigned CH_MODE_LSB  = 6;
  localparam int unsigned CH_FN_LSB    = 4;
  localparam int unsigned CH_LVL       = 3;
  localparam int unsigned CH_INV       = 2;
  localparam int unsigned CHA_DIR      = 1;
  localparam int unsigned CHA_CLR      = 0;
  localparam int unsigned CHB_ALN_LSB  = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [9:0] CMP_RESET  = 10'h000;
  localparam logic [9:0] CNT_MAX    = 10'h3ff;
  localparam logic [6:0] PERIOD_LOW = 7'h7f;
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam logic [5:0] DIV64_LAST = 6'h3f;
  localparam logic [1:0] DIV4_LAST  = 2'h3;

  typedef enum logic [2:0] {
    CK_SYS4     = 3'b000,
    CK_SYS      = 3'b001,
    CK_H16      = 3'b010,
    CK_H64      = 3'b011,
    CK_TBC      = 3'b100,
    CK_UNDEF    = 3'b101,
    CK_EXT_RISE = 3'b110,
    CK_EXT_FALL = 3'b111
  } etm_clksel_t;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } etm_mode_t;

  // pin function codes, compare / pwm / capture meaning, then alignment codes
  localparam logic [1:0] FN_NONE     = 2'b00;
  localparam logic [1:0] FN_LOW      = 2'b01;
  localparam logic [1:0] FN_HIGH     = 2'b10;
  localparam logic [1:0] FN_TOGGLE   = 2'b11;
  localparam logic [1:0] FN_INACTIVE = 2'b00;
  localparam logic [1:0] FN_ACTIVE   = 2'b01;
  localparam logic [1:0] FN_PWM      = 2'b10;
  localparam logic [1:0] FN_SINGLE   = 2'b11;
  localparam logic [1:0] CAP_RISE    = 2'b00;
  localparam logic [1:0] CAP_FALL    = 2'b01;
  localparam logic [1:0] CAP_BOTH    = 2'b10;
  localparam logic [1:0] ALN_EDGE    = 2'b00;
  localparam logic [1:0] ALN_UP      = 2'b01;
  localparam logic [1:0] ALN_DOWN    = 2'b10;
  localparam logic [1:0] ALN_BOTH    = 2'b11;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } etm_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } etm_wb_rsp_t;

  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  chanA;
    logic [7:0]  chanB;
    logic [9:0]  cmpA;
    logic [9:0]  cmpB;
    logic [9:0]  cnt;
    logic        dirDown;
    logic        lvlA;
    logic        lvlB;
    logic        onPrev;
    logic [1:0]  div4;
    logic [5:0]  divH;
    logic [1:0]  extSync;
    logic        extPrev;
    logic [1:0]  capSyncA;
    logic        capPrevA;
    logic [1:0]  capSyncB;
    logic        capPrevB;
    logic        ack;
    logic [31:0] rdat;
  } etm_state_t;

endpackage : etm_pkg

// ---- dv/etm_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module etm_pin_model
(
  input  wire logic       ref_clk,
  input  wire logic       chanAPinOut,
  input  wire logic       chanAPinOe,
  input  wire logic [2:0] chanBPinOut,
  input  wire logic [2:0] chanBPinOe,
  output logic            extCountPin,
  output logic            chanAPinIn,
  output logic            chanBPin0In
);
  logic extLvl  = 1'b0;
  logic capLvlA = 1'b0;

  // a pad shows the device level while it drives, else ours
  assign extCountPin = extLvl;
  assign chanAPinIn  = chanAPinOe ? chanAPinOut : capLvlA;
  // channel B pin 0 sees the same capture stimulus as channel A
  assign chanBPin0In = chanBPinOe[0] ? chanBPinOut[0] : capLvlA;

  // count clock only moves inside a burst, idle low between bursts
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      extLvl <= 1'b1;
      repeat (4) @(posedge ref_clk);
      extLvl <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask : pulses

  task automatic setCapA(input logic v);
    @(posedge ref_clk);
    capLvlA <= v;
  endtask : setCapA
endmodule : etm_pin_model

`default_nettype wire

// ---- dv/enhanced_timer_module_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module enhanced_timer_module_control_tb;
  import etm_pkg::*;

  logic        ref_clk;
  logic        reset;
  logic        highSpeedTick;
  logic        timebaseTick;
  logic        extCountPin;
  logic        chanAPinIn;
  logic        chanBPin0In;
  etm_wb_req_t wbReq;
  logic        wbAck;
  logic [31:0] wbDat;
  logic        chanAPinOut;
  logic        chanAPinOe;
  logic [2:0]  chanBPinOut;
  logic [2:0]  chanBPinOe;
  logic        moduleActive;
  logic [4:0]  tickDiv;
  logic [31:0] rdat;
  logic [31:0] e;
  logic        ini;
  logic        fin;
  logic [3:0]  wbSel = 4'hf;
  int          errCount;
  int          nCompared;
  int          divT [5] = '{4, 1, 32, 128, 32};

  etm_timer_ctrl i_dut (.ref_clk(ref_clk), .reset(reset),
    .highSpeedTick(highSpeedTick), .timebaseTick(timebaseTick),
    .extCountPin(extCountPin), .wbReq(wbReq), .wbAck(wbAck),
    .wbDat(wbDat), .chanAPinIn(chanAPinIn), .chanAPinOut(chanAPinOut),
    .chanAPinOe(chanAPinOe), .chanBPin0In(chanBPin0In),
    .chanBPinOut(chanBPinOut), .chanBPinOe(chanBPinOe),
    .moduleActive(moduleActive));

  etm_pin_model i_pins (.ref_clk(ref_clk), .chanAPinOut(chanAPinOut),
    .chanAPinOe(chanAPinOe), .chanBPinOut(chanBPinOut),
    .chanBPinOe(chanBPinOe), .extCountPin(extCountPin),
    .chanAPinIn(chanAPinIn), .chanBPin0In(chanBPin0In));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // high-speed tick every 2nd cycle, timebase tick every 32nd
  always @(posedge ref_clk)
  begin
    tickDiv       <= tickDiv + 5'h01;
    highSpeedTick <= tickDiv[0];
    timebaseTick  <= (tickDiv == 5'h1f);
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      errCount++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    wbReq <= '{1'b1, 1'b1, we, adr, wbSel, d};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    rdat = wbDat;
    check({31'h0, wbAck}, 32'h1);
    wbReq <= '0;
  endtask : xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    xfer(1'b1, adr, d);
  endtask : wr

  task automatic rd(input logic [7:0] adr);
    xfer(1'b0, adr, 32'h0);
  endtask : rd

  // off before any mode change, then on with the given clock and period
  task automatic extRun(input logic [2:0] ck, input logic [2:0] rp,
                        input logic [7:0] chA, input int n);
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_CHANA, {24'h0, chA});
    wr(ADDR_CTRL0, {24'h0, 1'b0, ck, 1'b1, rp});
    i_pins.pulses(n);
    repeat (6) @(posedge ref_clk);
    rd(ADDR_COUNT);
  endtask : extRun

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    errCount++;
    summarize();
  end

  initial
  begin
    reset = 1'b1;
    wbReq = '0;
    tickDiv = 5'h00;
    highSpeedTick = 1'b0;
    timebaseTick = 1'b0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    for (int a = 0; a < 6; a++)
    begin
      rd(8'(a * 4));
      check(rdat, 32'h0);
    end
    check({31'h0, moduleActive}, 32'h0);
    wr(ADDR_CTRL0, 32'hf7);
    rd(ADDR_CTRL0);
    check(rdat, 32'hf7);
    wr(ADDR_CHANA, 32'h3f);
    rd(ADDR_CHANA);
    check(rdat, 32'h3d);
    wr(ADDR_CHANB, 32'hff);
    rd(ADDR_CHANB);
    check(rdat, 32'hff);
    wr(8'h18, 32'hff);
    rd(8'h18);
    check(rdat, 32'h0);
    wr(ADDR_CHANA, 32'h0);
    wr(ADDR_CHANB, 32'h0);
    for (int s = 0; s < 5; s++)
    begin
      wr(ADDR_CTRL0, 32'h0);
      wr(ADDR_CTRL0, {24'h0, 1'b0, 3'(s), 1'b1, 3'h0});
      repeat (512) @(posedge ref_clk);
      wr(ADDR_CTRL0, {24'h0, 1'b1, 3'(s), 1'b1, 3'h0});
      rd(ADDR_COUNT);
      e = 32'(512 / divT[s]);
      check({31'h0, rdat + 3 >= e && rdat <= e + 3}, 32'h1);
    end
    e = rdat;
    wr(ADDR_CTRL0, 32'h0);
    check({31'h0, moduleActive}, 32'h0);
    repeat (50) @(posedge ref_clk);
    rd(ADDR_COUNT);
    check(rdat, e);
    wr(ADDR_CTRL0, {24'h0, 1'b0, 3'h5, 1'b1, 3'h0});
    repeat (100) @(posedge ref_clk);
    rd(ADDR_COUNT);
    check(rdat, 32'h0);
    extRun(3'h6, 3'h0, 8'h00, 5);
    check(rdat, 32'h5);
    wr(ADDR_CTRL0, {24'h0, 1'b1, 3'h6, 1'b1, 3'h0});
    i_pins.pulses(3);
    rd(ADDR_COUNT);
    check(rdat, 32'h5);
    wr(ADDR_CTRL0, {24'h0, 1'b0, 3'h6, 1'b1, 3'h0});
    i_pins.pulses(2);
    repeat (6) @(posedge ref_clk);
    rd(ADDR_COUNT);
    check(rdat, 32'h7);
    extRun(3'h7, 3'h0, 8'h00, 5);
    check(rdat, 32'h5);
    extRun(3'h6, 3'h1, 8'h00, 130);
    check(rdat, 32'h2);
    extRun(3'h6, 3'h0, 8'h00, 1026);
    check(rdat, 32'h2);
    wr(ADDR_CMPA, 32'ha);
    extRun(3'h6, 3'h0, 8'h01, 13);
    check(rdat, 32'h2);
    extRun(3'h6, 3'h0, 8'h71, 13);
    check(rdat, 32'hd);
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_CHANB, 32'ha1);
    extRun(3'h6, 3'h1, 8'ha0, 130);
    rd(ADDR_CHANA);
    check({31'h0, rdat[CHA_DIR]}, 32'h1);
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_CHANB, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      ini = 1'(4'h3 >> i);
      fin = (i == 0) ? ini : (i == 3) ? ~ini : (i == 2);
      e = {24'h0, 2'h0, 2'(i), ini, 1'((4'ha >> i)), 2'h0};
      wr(ADDR_CMPA, 32'h3);
      wr(ADDR_CMPB, 32'h3);
      wr(ADDR_CHANB, e);
      extRun(3'h6, 3'h0, e[7:0], 0);
      ini = ini ^ e[CH_INV];
      check({27'h0, chanAPinOe, chanAPinOut, chanBPinOut},
            {27'h0, 1'b1, ini, {3{ini}}});
      i_pins.pulses(5);
      repeat (6) @(posedge ref_clk);
      fin = fin ^ e[CH_INV];
      check({28'h0, chanAPinOut, chanBPinOut},
            {28'h0, fin, {3{fin}}});
      wr(ADDR_CTRL0, 32'h0);
      wr(ADDR_CTRL0, {24'h0, 1'b0, 3'h6, 1'b1, 3'h0});
      repeat (3) @(posedge ref_clk);
      check({28'h0, chanAPinOut, chanBPinOut},
            {28'h0, ini, {3{ini}}});
    end
    for (int f = 0; f < 2; f++)
    begin
      extRun(3'h5, 3'h0, {2'h2, 2'(f), 4'h8}, 0);
      repeat (4) @(posedge ref_clk);
      check({31'h0, chanAPinOut}, 32'(f));
    end
    wr(ADDR_CMPA, 32'h3);
    extRun(3'h1, 3'h0, 8'hb8, 0);
    check(rdat, 32'h4);
    check({30'h0, moduleActive, chanAPinOut}, 32'h0);
    i_pins.pulses(1);
    check({30'h0, moduleActive, chanAPinOut}, 32'h3);
    wr(ADDR_CTRL0, 32'h0);
    wr(ADDR_CHANA, 32'hc0);
    repeat (2) @(posedge ref_clk);
    check({31'h0, chanAPinOe}, 32'h0);
    wr(ADDR_CMPA, 32'h155);
    wbSel = 4'h1;
    wr(ADDR_CMPA, 32'h3aa);
    wbSel = 4'hf;
    rd(ADDR_CMPA);
    check(rdat, 32'h1aa);
    for (int f = 0; f < 4; f++)
    begin
      wr(ADDR_CTRL0, 32'h0);
      wr(ADDR_CMPA, 32'h155);
      wr(ADDR_CMPB, 32'h155);
      wr(ADDR_CHANB, {24'h0, 2'h1, 2'(f), 4'h0});
      extRun(3'h6, 3'h0, {2'h1, 2'(f), 4'h0}, 4);
      i_pins.setCapA(1'b1);
      repeat (6) @(posedge ref_clk);
      rd(ADDR_CMPA);
      e = (f == 0 || f == 2) ? 32'h4 : 32'h155;
      check(rdat, e);
      rd(ADDR_CMPB);
      check(rdat, e);
      i_pins.pulses(1);
      i_pins.setCapA(1'b0);
      repeat (6) @(posedge ref_clk);
      rd(ADDR_CMPA);
      check(rdat, (f == 1 || f == 2) ? 32'h5 : e);
      rd(ADDR_CMPB);
      check(rdat, (f == 1 || f == 2) ? 32'h5 : e);
    end
    summarize();
  end
endmodule : enhanced_timer_module_control_tb

`default_nettype wire
